// File: verilog/cau_pkg.sv
// constants and types shared by the coax attachment unit core
package cau_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_CELL_NS = 100;
  localparam int BIT_CYCLES = BIT_CELL_NS / CLK_PERIOD_NS;

  localparam int TX_DROP_MAX_BITS = 2;
  localparam int RX_DROP_MAX_BITS = 5;
  localparam int PATH_DELAY_MAX_CYCLES = BIT_CYCLES / 2;

  // a gap of 1.6 bit cells without a transition means idle
  localparam int IDLE_TENTHS = 16;
  localparam logic [7:0] IDLE_CYCLES = 8'(BIT_CYCLES * IDLE_TENTHS / 10);
  localparam logic [1:0] START_EDGES = 2'h2;

  localparam int SQE_DELAY_MIN_NS = 600;
  localparam int SQE_DELAY_MAX_NS = 1600;
  localparam int SQE_DELAY_NS = 1000;
  localparam logic [7:0] SQE_DELAY_CYCLES = 8'(SQE_DELAY_NS / CLK_PERIOD_NS);
  localparam int SQE_HOLD_BITS = 10;
  localparam logic [7:0] SQE_HOLD_CYCLES = 8'(SQE_HOLD_BITS * BIT_CYCLES);
  localparam logic [7:0] SQE_END_CYCLES = 8'(SQE_DELAY_CYCLES + SQE_HOLD_CYCLES);
  localparam logic [2:0] TONE_HALF_CYCLES = 3'(BIT_CYCLES / 2);
  localparam int COLL_MAX_BITS = 9;

  localparam int JABBER_MIN_MS = 20;
  localparam int JABBER_MAX_MS = 150;
  localparam int JABBER_MS = 50;
  localparam int unsigned JABBER_CYCLES = JABBER_MS * (1000000 / CLK_PERIOD_NS);

  localparam int ISOLATE_MAX_MS = 20;
  localparam logic [3:0] ISOLATE_EDGES = 4'h8;

  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_WIDTH = 4;

  typedef enum logic [0:0] {
    CAU_NORMAL = 1'b0,
    CAU_MONITOR = 1'b1
  } cau_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_FRAME = 2'b01,
    TX_POST = 2'b10,
    TX_JAB = 2'b11
  } cau_tx_state_t;

endpackage : cau_pkg

// File: verilog/cau_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module cau_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } cau_sync_st_t;

  cau_sync_st_t q;
  cau_sync_st_t d;

  // first stage feeds the second stage only
  always_comb begin
    d = q;
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.s2;
endmodule : cau_sync
`default_nettype wire

// File: verilog/cau_fifo.sv
// small sample fifo with flush, valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module cau_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } cau_fifo_st_t;

  cau_fifo_st_t q;
  cau_fifo_st_t d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : next_ptr

  assign in_ready = (q.cnt != (AW + 1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    d = q;
    if (flush) begin
      d.wr = '0;
      d.rd = '0;
      d.cnt = '0;
    end else begin
      if (push) begin
        d.mem[q.wr] = in_data;
        d.wr = next_ptr(q.wr);
      end
      if (pop) begin
        d.rd = next_ptr(q.rd);
      end
      case ({push, pop})
        2'b10: d.cnt = q.cnt + 1'b1;
        2'b01: d.cnt = q.cnt - 1'b1;
        default: d.cnt = q.cnt;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : cau_fifo
`default_nettype wire

// File: verilog/cau_core.sv
// coax attachment unit core: transmit, receive, collision, monitor and jabber
// Contract
// - drop at most two bit cells at start
// - only first transmitted bit may be bad
// - transmit delay at most half bit cell
// - transmit path never inverts polarity
// - threshold of transitions before transmitting
// - post-frame indication 0.6-1.6us, 10 bits
// - drop at most five bit cells receiving
// - only first received bit may be bad
// - receive delay half bit, no inversion
// - normal mode passes both directions
// - monitor mode silences transmitter only
// - report concurrent transmissions as collision
// - jabber cuts overlong transmissions
// - collision tone within nine bit times
// - no indication with single transmitter
// - jabber window 20 to 150 ms
// - isolate request disables transmitter quickly
`timescale 1ns/10ps
`default_nettype none
module cau_core
  import cau_pkg::*;
#(
  parameter int unsigned JABBER_LIMIT = JABBER_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic transmit_data_pair,
  input wire logic control_out_pair,
  input wire logic medium_rx_in,
  input wire logic medium_collision_level,
  output logic medium_tx_out,
  output logic medium_tx_oe_n,
  output logic receive_data_pair,
  output logic collision_indication_pair,
  output logic monitor_mode,
  output logic jabber_active
);

  typedef struct packed {
    cau_mode_t mode;
    cau_tx_state_t tx_st;
    logic tx_prev;
    logic [1:0] tx_edges;
    logic [7:0] tx_gap;
    logic [7:0] post_cnt;
    logic [31:0] jab_cnt;
    logic co_prev;
    logic [7:0] co_gap;
    logic [3:0] co_edges;
    logic rx_prev;
    logic [7:0] rx_gap;
    logic rx_on;
    logic [2:0] tone_cnt;
    logic tone;
    logic tx_out;
    logic tx_oe_n;
    logic rx_out;
    logic ci_out;
    logic jabber;
  } cau_core_st_t;

  localparam cau_core_st_t RESET_ST = '{
    mode: CAU_NORMAL, tx_st: TX_IDLE, tx_oe_n: 1'b1, default: '0};

  cau_core_st_t q;
  cau_core_st_t d;
  logic [SYNC_WIDTH-1:0] pins_sync;
  logic tx_sync;
  logic co_sync;
  logic rx_sync;
  logic coll_sync;
  logic fifo_flush;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_out_data;
  logic tx_edge;
  logic co_edge;
  logic rx_edge;
  logic post_sqe;
  logic sqe_req;

  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction : sat_inc

  cau_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({medium_collision_level, medium_rx_in, control_out_pair, transmit_data_pair}),
    .sync_out(pins_sync)
  );

  assign tx_sync = pins_sync[0];
  assign co_sync = pins_sync[1];
  assign rx_sync = pins_sync[2];
  assign coll_sync = pins_sync[3];

  assign tx_edge = tx_sync ^ q.tx_prev;
  assign co_edge = co_sync ^ q.co_prev;
  assign rx_edge = rx_sync ^ q.rx_prev;

  // flush at frame start so a backlog left from an earlier frame never adds latency
  assign fifo_flush = (q.tx_st == TX_IDLE) && (d.tx_st == TX_FRAME);
  assign fifo_in_valid = (q.tx_st == TX_FRAME);
  // drain stalls in monitor mode; fill side then backs up and jabber timing pauses
  assign fifo_out_ready = (q.tx_st == TX_FRAME) && (q.mode == CAU_NORMAL);

  cau_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(tx_sync),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  assign post_sqe = (q.tx_st == TX_POST) && (q.post_cnt >= SQE_DELAY_CYCLES)
                    && (q.post_cnt < SQE_END_CYCLES);
  // the level comparator trips only at two or more drivers' dc average
  assign sqe_req = coll_sync || post_sqe || q.jabber;

  always_comb begin
    d = q;
    d.tx_prev = tx_sync;
    d.co_prev = co_sync;
    d.rx_prev = rx_sync;

    // mode register driven by the control pair messages
    d.co_gap = co_edge ? 8'h00 : sat_inc(q.co_gap);
    if (co_edge) begin
      if (q.co_edges != ISOLATE_EDGES) begin
        d.co_edges = q.co_edges + 4'h1;
      end
    end else if (q.co_gap >= IDLE_CYCLES) begin
      d.co_edges = 4'h0;
    end
    if (co_edge && (q.co_edges == ISOLATE_EDGES - 4'h1)) begin
      d.mode = CAU_MONITOR;
    end else if (!co_edge && (q.co_gap >= IDLE_CYCLES)) begin
      d.mode = CAU_NORMAL;
    end

    // transmit sequencer
    d.tx_gap = tx_edge ? 8'h00 : sat_inc(q.tx_gap);
    case (q.tx_st)
      TX_IDLE: begin
        d.jab_cnt = '0;
        d.post_cnt = 8'h00;
        if (tx_edge) begin
          d.tx_edges = q.tx_edges + 2'h1;
          // noise below the threshold never opens a frame
          if (q.tx_edges == START_EDGES - 2'h1) begin
            d.tx_st = TX_FRAME;
            d.tx_edges = 2'h0;
          end
        end else if (q.tx_gap >= IDLE_CYCLES) begin
          d.tx_edges = 2'h0;
        end
      end
      TX_FRAME: begin
        if (fifo_in_valid && fifo_in_ready) begin
          d.jab_cnt = q.jab_cnt + 32'h1;
        end
        if (q.jab_cnt >= 32'(JABBER_LIMIT)) begin
          d.tx_st = TX_JAB;
          d.jabber = 1'b1;
        end else if (!tx_edge && (q.tx_gap >= IDLE_CYCLES)) begin
          d.tx_st = TX_POST;
          d.post_cnt = IDLE_CYCLES;
        end
      end
      TX_POST: begin
        // new edges are ignored until the indication has finished
        d.post_cnt = sat_inc(q.post_cnt);
        if (q.post_cnt >= SQE_END_CYCLES - 8'h01) begin
          d.tx_st = TX_IDLE;
          d.tx_edges = 2'h0;
        end
      end
      TX_JAB: begin
        // only the isolate request clears a latched jabber
        if (q.mode == CAU_MONITOR) begin
          d.tx_st = TX_IDLE;
          d.jabber = 1'b0;
          d.tx_edges = 2'h0;
        end
      end
      default: begin
        d.tx_st = TX_IDLE;
      end
    endcase

    // transmit drive, gated by mode and jabber; no inversion
    if ((q.tx_st == TX_FRAME) && (q.mode == CAU_NORMAL) && fifo_out_valid) begin
      d.tx_out = fifo_out_data;
      d.tx_oe_n = 1'b0;
    end else begin
      d.tx_out = 1'b0;
      d.tx_oe_n = 1'b1;
    end

    // receive path runs in both modes; forwarding starts on the first edge
    d.rx_gap = rx_edge ? 8'h00 : sat_inc(q.rx_gap);
    if (rx_edge) begin
      d.rx_on = 1'b1;
    end else if (q.rx_gap >= IDLE_CYCLES) begin
      d.rx_on = 1'b0;
    end
    d.rx_out = (q.rx_on || rx_edge) ? rx_sync : 1'b0;

    // collision tone at the bit rate, idle level otherwise
    if (!sqe_req) begin
      d.tone_cnt = 3'h0;
      d.tone = 1'b0;
    end else if (q.tone_cnt == 3'h0) begin
      d.tone = !q.tone;
      d.tone_cnt = TONE_HALF_CYCLES - 3'h1;
    end else begin
      d.tone_cnt = q.tone_cnt - 3'h1;
    end
    d.ci_out = sqe_req ? d.tone : 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= RESET_ST;
    end else begin
      q <= d;
    end
  end

  assign medium_tx_out = q.tx_out;
  assign medium_tx_oe_n = q.tx_oe_n;
  assign receive_data_pair = q.rx_out;
  assign collision_indication_pair = q.ci_out;
  assign monitor_mode = q.mode;
  assign jabber_active = q.jabber;

  default clocking cau_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  tx_start_drive_a: assert property (
    ($rose(q.tx_st == TX_FRAME) && (q.mode == CAU_NORMAL) && $stable(q.mode))
      |-> ##[1:3] !medium_tx_oe_n || (q.mode == CAU_MONITOR))
    else $error("transmit not driven soon after frame start");

  tx_copy_exact_a: assert property (
    (!medium_tx_oe_n && $past(!medium_tx_oe_n)) |-> (medium_tx_out == $past(tx_sync, 2)))
    else $error("medium output does not follow transmit data");

  rx_copy_exact_a: assert property (
    q.rx_on |-> (receive_data_pair == $past(rx_sync)))
    else $error("receive pair does not follow medium");

  monitor_silent_a: assert property (
    (q.mode == CAU_MONITOR) |=> medium_tx_oe_n)
    else $error("transmitter active in monitor mode");

  post_sqe_start_a: assert property (
    ($rose(q.tx_st == TX_POST) && !coll_sync) |-> ##[60:100] collision_indication_pair)
    else $error("post-frame indication late");

  post_sqe_end_a: assert property (
    ((q.tx_st == TX_POST) && (q.post_cnt == SQE_END_CYCLES - 8'h01)) |=> (q.tx_st == TX_IDLE))
    else $error("post-frame indication length wrong");

  coll_tone_fast_a: assert property (
    $rose(coll_sync) |-> ##[1:9] collision_indication_pair)
    else $error("collision tone too late");

  no_false_coll_a: assert property (
    collision_indication_pair |-> $past(sqe_req))
    else $error("collision tone without cause");

  jabber_block_a: assert property (
    jabber_active |=> medium_tx_oe_n)
    else $error("output not blocked while jabber latched");

  isolate_take_a: assert property (
    (co_edge && (q.co_edges == ISOLATE_EDGES - 4'h1)) |=> monitor_mode)
    else $error("isolate request not taken");

  frame_seen_c: cover property ($rose(q.tx_st == TX_FRAME));
  post_sqe_c: cover property (post_sqe && collision_indication_pair);
  jabber_hit_c: cover property ($rose(jabber_active));
  monitor_on_c: cover property ($rose(monitor_mode));

endmodule : cau_core
`default_nettype wire

// File: verification/cau_station_model.sv
// station-side model driving the transmit and control pairs
`timescale 1ns/10ps
`default_nettype none
module cau_station_model (
  input wire logic clk,
  output logic tx_pair,
  output logic ctl_pair
);
  initial begin
    tx_pair = 1'b0;
    ctl_pair = 1'b0;
  end

  // split-phase bits of five clocks a half; line ends low so idle is clean
  task automatic send_frame(input int nbits);
    logic b;
    for (int i = 0; i < nbits; i++) begin
      b = 1'($urandom);
      repeat (5) @(posedge clk) tx_pair <= ~b;
      repeat (5) @(posedge clk) tx_pair <= b;
    end
    @(posedge clk) tx_pair <= 1'b0;
  endtask : send_frame

  // lone edges far apart, too weak to open a frame
  task automatic stray_edge();
    @(posedge clk) tx_pair <= 1'b1;
    repeat (30) @(posedge clk);
    tx_pair <= 1'b0;
  endtask : stray_edge

  // tone on the control pair asks for isolation, steady level asks for normal
  task automatic send_isolate(input int ntog);
    for (int i = 0; i < ntog; i++) begin
      repeat (5) @(posedge clk);
      ctl_pair <= ~ctl_pair;
    end
    repeat (5) @(posedge clk);
    ctl_pair <= 1'b0;
  endtask : send_isolate
endmodule : cau_station_model
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for the coax attachment unit core
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cau_pkg::*;
  // short jabber window keeps the run brief
  localparam int unsigned JAB = 2000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic rx_pin = 1'b0;
  logic coll_pin = 1'b0;
  logic tx_pin, ctl_pin, tx_out, oe_n, rx_out, ci, mon, jab;
  int fail_count = 0;
  int cmp_count = 0;
  int quiet = 0;
  int rx_run = 0;
  int cyc = 0;
  int tx_last = 0;
  logic txq[$];
  logic rxq[$];

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  cau_core #(.JABBER_LIMIT(JAB)) i_cau_core (.clk(clk), .reset_n(reset_n), .transmit_data_pair(tx_pin),
    .control_out_pair(ctl_pin), .medium_rx_in(rx_pin), .medium_collision_level(coll_pin),
    .medium_tx_out(tx_out), .medium_tx_oe_n(oe_n), .receive_data_pair(rx_out),
    .collision_indication_pair(ci), .monitor_mode(mon), .jabber_active(jab));
  cau_station_model i_cau_station_model (.clk(clk), .tx_pair(tx_pin), .ctl_pair(ctl_pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s seen %0h exp %0h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic wait_for(ref logic sig, input logic val, input int lim, output int n);
    n = 0;
    while (sig !== val && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_for

  // the bench stands in for the coax when traffic arrives from it
  task automatic rx_frame(input int nbits);
    logic b;
    for (int i = 0; i < nbits; i++) begin
      b = 1'($urandom);
      repeat (5) @(posedge clk) rx_pin <= ~b;
      repeat (5) @(posedge clk) rx_pin <= b;
    end
    @(posedge clk) rx_pin <= 1'b0;
  endtask : rx_frame

  // reference model: pin history queues give the expected data paths every cycle
  always @(posedge clk) begin
    if (reset_n === 1'b1 && txq.size() > 3) begin
      if (oe_n === 1'b0) check(tx_out, txq[3], "tx data");
      else check(tx_out, 0, "tx quiet");
      if (rx_run > 2 * BIT_CYCLES) check(rx_out, rxq[2], "rx data");
      if (quiet > 30) check(rx_out, 0, "rx idle");
    end
    quiet = (rxq.size() > 0 && rxq[0] !== rx_pin) ? 0 : quiet + 1;
    rx_run = (quiet > 16) ? 0 : rx_run + 1;
    if (txq.size() > 0 && txq[0] !== tx_pin) tx_last = cyc;
    cyc++;
    txq.push_front(tx_pin);
    rxq.push_front(rx_pin);
    if (txq.size() > 8) begin
      void'(txq.pop_back());
      void'(rxq.pop_back());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    test_done();
  end

  initial begin
    int n;
    int last;
    void'($urandom(51002));
    repeat (5) @(posedge clk);
    #1;
    check(oe_n, 1, "reset oe");
    check({tx_out, rx_out, ci, mon, jab}, 0, "reset outs");
    @(posedge clk) reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    fork
      i_cau_station_model.stray_edge();
      wait_for(oe_n, 1'b0, 60, n);
    join
    check(n, 60, "stray start");
    repeat (40) @(posedge clk);
    fork
      i_cau_station_model.send_frame(16);
      begin
        wait_for(oe_n, 1'b0, 40, n);
        check(n <= 2 * BIT_CYCLES + PATH_DELAY_MAX_CYCLES + 1, 1, "drive start");
        wait_for(ci, 1'b1, 120, n);
        check(n, 120, "ci in frame");
      end
    join
    wait_for(ci, 1'b1, 250, n);
    n = cyc - tx_last;
    check(n >= SQE_DELAY_MIN_NS / CLK_PERIOD_NS && n <= SQE_DELAY_MAX_NS / CLK_PERIOD_NS, 1, "ci delay");
    last = 0;
    for (int i = 1; i <= 250; i++) begin
      @(posedge clk);
      #1;
      if (ci === 1'b1) last = i;
    end
    check(last >= 4 * BIT_CYCLES && last <= 15 * BIT_CYCLES, 1, "ci length");
    fork
      rx_frame(20);
      begin
        repeat (60) @(posedge clk);
        #1;
        check(ci, 0, "rx only");
        @(posedge clk) coll_pin <= 1'b1;
        wait_for(ci, 1'b1, 100, n);
        check(n <= COLL_MAX_BITS * BIT_CYCLES, 1, "coll normal");
        repeat (30) @(posedge clk);
        coll_pin <= 1'b0;
      end
    join
    repeat (50) @(posedge clk);
    #1;
    check(ci, 0, "coll gone");
    fork
      i_cau_station_model.send_frame(250);
      begin
        wait_for(oe_n, 1'b0, 40, n);
        wait_for(jab, 1'b1, JAB + 60, n);
        check(n >= JAB - 30 && n <= JAB + 30, 1, "jabber time");
        @(posedge clk);
        #1;
        check(oe_n, 1, "jabber cut");
      end
    join
    check(jab, 1, "jabber held");
    fork
      i_cau_station_model.send_isolate(60);
      begin
        wait_for(mon, 1'b1, 100, n);
        check(n <= 8 * 5 + 10, 1, "isolate");
        repeat (4) @(posedge clk);
        #1;
        check(jab, 0, "jabber reset");
        fork
          i_cau_station_model.send_frame(8);
          rx_frame(8);
          begin
            @(posedge clk) coll_pin <= 1'b1;
            wait_for(ci, 1'b1, 100, n);
            check(n <= COLL_MAX_BITS * BIT_CYCLES, 1, "coll monitor");
            @(posedge clk) coll_pin <= 1'b0;
          end
          begin
            wait_for(oe_n, 1'b0, 100, n);
            check(n, 100, "monitor silent");
          end
        join
      end
    join
    wait_for(mon, 1'b0, 40, n);
    check(n <= 30, 1, "normal back");
    repeat (300) @(posedge clk);
    fork
      i_cau_station_model.send_frame(6);
      wait_for(oe_n, 1'b0, 40, n);
    join
    check(n <= 2 * BIT_CYCLES + PATH_DELAY_MAX_CYCLES + 1, 1, "drive again");
    repeat (300) @(posedge clk);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
